// [src/pin_state_pkg.sv]
package pin_state_pkg;

   // --------------------------------------------------------------
   // Condition encodings
   // --------------------------------------------------------------
   typedef enum logic [3:0] {
      PM_FULL      = 4'h1,
      PM_STANDBY   = 4'h2,
      PM_SUSPEND   = 4'h4,
      PM_HIBERNATE = 4'h8
   } power_mode_type;

   typedef enum logic [3:0] {
      CAUSE_RTC     = 4'h1,
      CAUSE_SWITCH  = 4'h2,
      CAUSE_DEADMAN = 4'h4,
      CAUSE_RUN     = 4'h8
   } reset_cause_type;

   // --------------------------------------------------------------
   // Two-pin group carrier, oe_n low while driving
   // --------------------------------------------------------------
   typedef struct packed {
      logic [1:0] level;
      logic [1:0] oe_n;
   } pin_pair_type;

   // --------------------------------------------------------------
   // Reset values and fixed levels
   // --------------------------------------------------------------
   localparam logic [1:0] PAIR_HIGH = 2'h3;
   localparam logic [1:0] PAIR_LOW = 2'h0;
   localparam logic [1:0] PAIR_DRIVE = 2'h0;
   localparam logic [1:0] PAIR_FLOAT = 2'h3;
   localparam pin_pair_type PAIR_RESET = '{level: PAIR_HIGH, oe_n: PAIR_FLOAT};
   localparam logic BUS_CLOCK_RESET = 1'h0;
   localparam logic SERIAL_IDLE = 1'h1;
   localparam int SYNC_STAGES = 3;

endpackage : pin_state_pkg

// [src/pin_hold_cell.sv]
`timescale 1ns/1ps
// Keeps the last full-speed level of a pin group while capture is off.
module pin_hold_cell #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Live side
   input wire logic capture_in,
   input wire logic [WIDTH-1:0] live_in,
   // Held side
   output logic [WIDTH-1:0] held_out
);

   if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] held_ff;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         held_ff <= RESET_LEVEL;
      end else if (capture_in) begin
         held_ff <= live_in;
      end
   end

   // Live value passes while capturing, so no cycle of lag at entry
   assign held_out = capture_in ? live_in : held_ff;

endmodule : pin_hold_cell

// [src/pin_state_mode_control.sv]
`timescale 1ns/1ps
// Summary of operation
// - Hold pins keep last full-speed level in suspend without a bus hold
// - Upper selects in ROM role mirror ROM selects while forced, else follow their own live value
// - Upper selects in DRAM role mirror row strobes while forced, but float high in reset; else follow their own live value
// - Width pin low when setting 1, else high
// - Reset switch reset: strobe low, self refresh
// - Watchdog reset: strobe drives high
// - Bus hold clock: frozen from suspend, else toggles
// - Shared serial pins switch role under software
module pin_state_mode_control #(
   parameter int SERIAL_W = 3
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Reset sources
   input wire logic clock_domain_reset_input_in,
   input wire logic reset_switch_input_n_in,
   input wire logic watchdog_timeout_in,
   input wire logic run_start_in,
   // Power state and bus hold
   input wire pin_state_pkg::power_mode_type power_mode_in,
   input wire logic bus_hold_grant_in,
   // Configuration
   input wire logic bus_width_select_in,
   input wire logic upper_rom_role_in,
   input wire logic [SERIAL_W-1:0] serial_gpio_role_in,
   // Functional values from the bus and serial logic
   input wire logic [1:0] rom_chip_select_n_live_in,
   input wire logic [1:0] dram_row_strobe_n_live_in,
   input wire logic [1:0] upper_select_n_live_in,
   input wire logic external_bus_clock_live_in,
   input wire logic [SERIAL_W-1:0] serial_live_in,
   input wire logic [SERIAL_W-1:0] gpio_live_in,
   // Pins
   output pin_state_pkg::pin_pair_type rom_chip_select_out,
   output pin_state_pkg::pin_pair_type dram_row_strobe_out,
   output pin_state_pkg::pin_pair_type upper_select_out,
   output logic external_bus_clock_out,
   output logic width_level_out,
   output logic width_oe_n_out,
   output logic [SERIAL_W-1:0] serial_level_out,
   output logic [SERIAL_W-1:0] serial_oe_n_out,
   // Status
   output pin_state_pkg::reset_cause_type reset_cause_out
);

   generate
      if (SERIAL_W < 1 || SERIAL_W > 16) begin : g_bad_width
         $error("SERIAL_W out of range");
      end
   endgenerate

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [pin_state_pkg::SYNC_STAGES-1:0] sw_sync_ff;
   logic [pin_state_pkg::SYNC_STAGES-1:0] rtc_sync_ff;
   logic sw_pressed_ff;
   logic rtc_active_ff;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sw_sync_ff <= '0;
         rtc_sync_ff <= '0;
      end else begin
         sw_sync_ff <= {sw_sync_ff[1:0], ~reset_switch_input_n_in};
         rtc_sync_ff <= {rtc_sync_ff[1:0], clock_domain_reset_input_in};
      end
   end

   // A level counts only once stages two and three agree
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sw_pressed_ff <= 1'h0;
         rtc_active_ff <= 1'h0;
      end else begin
         if (sw_sync_ff[1] == sw_sync_ff[2]) begin
            sw_pressed_ff <= sw_sync_ff[2];
         end
         if (rtc_sync_ff[1] == rtc_sync_ff[2]) begin
            rtc_active_ff <= rtc_sync_ff[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Reset cause
   // ------------------------------------------------------------
   pin_state_pkg::reset_cause_type cause_ff;

   // Clock-domain reset outranks the switch, the switch the watchdog
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         cause_ff <= pin_state_pkg::CAUSE_RTC;
      end else if (rtc_active_ff) begin
         cause_ff <= pin_state_pkg::CAUSE_RTC;
      end else if (sw_pressed_ff) begin
         cause_ff <= pin_state_pkg::CAUSE_SWITCH;
      end else if (watchdog_timeout_in) begin
         cause_ff <= pin_state_pkg::CAUSE_DEADMAN;
      end else if (run_start_in) begin
         cause_ff <= pin_state_pkg::CAUSE_RUN;
      end
   end

   assign reset_cause_out = cause_ff;

   // ------------------------------------------------------------
   // Operating condition
   // ------------------------------------------------------------
   logic running;
   logic full_speed;
   logic suspended;
   logic hibernating;
   logic holding;
   logic hold_from_suspend_ff;
   logic capture;
   logic forced;

   assign running = cause_ff == pin_state_pkg::CAUSE_RUN;
   assign suspended = power_mode_in == pin_state_pkg::PM_SUSPEND;
   assign hibernating = power_mode_in == pin_state_pkg::PM_HIBERNATE;
   assign full_speed = power_mode_in == pin_state_pkg::PM_FULL;
   assign holding = running && bus_hold_grant_in;
   assign capture = running && full_speed && !bus_hold_grant_in;
   // Any condition in which the select and strobe pins do not follow their live values
   assign forced = !running || holding || suspended || hibernating;

   // Remember where the hold began; suspend may end during the hold
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         hold_from_suspend_ff <= 1'h0;
      end else if (!holding) begin
         hold_from_suspend_ff <= suspended;
      end
   end

   // ------------------------------------------------------------
   // Levels held from full speed
   // ------------------------------------------------------------
   logic held_clock;
   logic [SERIAL_W-1:0] serial_mux;
   logic [SERIAL_W-1:0] held_serial;

   assign serial_mux = (serial_gpio_role_in & gpio_live_in)
                     | (~serial_gpio_role_in & serial_live_in);

   pin_hold_cell #(.WIDTH(1), .RESET_LEVEL(pin_state_pkg::BUS_CLOCK_RESET)) u_clock_hold (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .capture_in(capture),
      .live_in(external_bus_clock_live_in),
      .held_out(held_clock)
   );

   pin_hold_cell #(.WIDTH(SERIAL_W), .RESET_LEVEL({SERIAL_W{pin_state_pkg::SERIAL_IDLE}}))
   u_serial_hold (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .capture_in(capture),
      .live_in(serial_mux),
      .held_out(held_serial)
   );

   // ------------------------------------------------------------
   // Per-condition pin levels
   // ------------------------------------------------------------
   pin_state_pkg::pin_pair_type nxt_rom;
   pin_state_pkg::pin_pair_type nxt_strobe;
   pin_state_pkg::pin_pair_type nxt_upper;
   pin_state_pkg::pin_pair_type upper_as_rom;
   pin_state_pkg::pin_pair_type upper_as_dram;
   logic nxt_clock;
   logic [SERIAL_W-1:0] nxt_serial;
   logic [SERIAL_W-1:0] nxt_serial_oe_n;

   // Chip-select column: used for the lower ROM selects and upper ROM role
   function automatic pin_state_pkg::pin_pair_type rom_col(
      input pin_state_pkg::reset_cause_type cause,
      input logic hold,
      input logic susp,
      input logic hib,
      input logic [1:0] live);
      pin_state_pkg::pin_pair_type r;
      r.level = pin_state_pkg::PAIR_HIGH;
      r.oe_n = pin_state_pkg::PAIR_DRIVE;
      if (cause == pin_state_pkg::CAUSE_RTC || (cause == pin_state_pkg::CAUSE_RUN && hib)) begin
         r.oe_n = pin_state_pkg::PAIR_FLOAT;
      end else if (cause == pin_state_pkg::CAUSE_RUN && !hold && !susp) begin
         r.level = live;
      end
      return r;
   endfunction : rom_col

   // Row-strobe column: used for lower strobes and upper DRAM role
   function automatic pin_state_pkg::pin_pair_type dram_col(
      input pin_state_pkg::reset_cause_type cause,
      input logic hold,
      input logic susp,
      input logic hib,
      input logic [1:0] live);
      pin_state_pkg::pin_pair_type r;
      r.level = pin_state_pkg::PAIR_LOW;
      r.oe_n = pin_state_pkg::PAIR_DRIVE;
      unique case (cause)
         pin_state_pkg::CAUSE_RTC: begin
            r.level = pin_state_pkg::PAIR_HIGH;
         end
         pin_state_pkg::CAUSE_SWITCH: begin
            r.level = pin_state_pkg::PAIR_LOW;
         end
         pin_state_pkg::CAUSE_DEADMAN: begin
            r.level = pin_state_pkg::PAIR_HIGH;
         end
         pin_state_pkg::CAUSE_RUN: begin
            if (hold) begin
               r.oe_n = pin_state_pkg::PAIR_FLOAT;
            end else if (!susp && !hib) begin
               r.level = live;
            end
         end
         default: begin
            r.level = pin_state_pkg::PAIR_HIGH;
         end
      endcase
      return r;
   endfunction : dram_col

   always_comb begin
      nxt_rom = rom_col(cause_ff, holding, suspended, hibernating, rom_chip_select_n_live_in);
      nxt_strobe = dram_col(cause_ff, holding, suspended, hibernating,
                            dram_row_strobe_n_live_in);
      upper_as_rom = rom_col(cause_ff, holding, suspended, hibernating,
                             upper_select_n_live_in);
      upper_as_dram = dram_col(cause_ff, holding, suspended, hibernating,
                               upper_select_n_live_in);
      nxt_upper = upper_rom_role_in ? upper_as_rom : upper_as_dram;
   end

   always_comb begin
      nxt_clock = pin_state_pkg::BUS_CLOCK_RESET;
      if (running) begin
         if (holding) begin
            nxt_clock = hold_from_suspend_ff ? held_clock : external_bus_clock_live_in;
         end else if (suspended) begin
            nxt_clock = held_clock;
         end else if (!hibernating) begin
            nxt_clock = external_bus_clock_live_in;
         end
      end
   end

   always_comb begin
      nxt_serial = {SERIAL_W{pin_state_pkg::SERIAL_IDLE}};
      nxt_serial_oe_n = '0;
      if (cause_ff == pin_state_pkg::CAUSE_RTC) begin
         nxt_serial_oe_n = '1;
      end else if (holding) begin
         nxt_serial = serial_mux;
      end else if (running && suspended) begin
         nxt_serial = held_serial;
      end else if (running && !hibernating) begin
         nxt_serial = serial_mux;
      end
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rom_chip_select_out <= pin_state_pkg::PAIR_RESET;
         upper_select_out <= pin_state_pkg::PAIR_RESET;
         dram_row_strobe_out <= '{level: pin_state_pkg::PAIR_HIGH,
                                  oe_n: pin_state_pkg::PAIR_DRIVE};
      end else begin
         rom_chip_select_out <= nxt_rom;
         upper_select_out <= nxt_upper;
         dram_row_strobe_out <= nxt_strobe;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         external_bus_clock_out <= pin_state_pkg::BUS_CLOCK_RESET;
         serial_level_out <= {SERIAL_W{pin_state_pkg::SERIAL_IDLE}};
         serial_oe_n_out <= '1;
      end else begin
         external_bus_clock_out <= nxt_clock;
         serial_level_out <= nxt_serial;
         serial_oe_n_out <= nxt_serial_oe_n;
      end
   end

   // Width pin is always driven, inverse of the setting
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         width_level_out <= 1'h1;
         width_oe_n_out <= 1'h0;
      end else begin
         width_level_out <= ~bus_width_select_in;
         width_oe_n_out <= 1'h0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   suspend_clock_a: assert property (running && suspended && !bus_hold_grant_in
      ##1 running && suspended && !bus_hold_grant_in |=> $stable(external_bus_clock_out))
      else $error("bus clock moved in suspend");
   upper_rom_a: assert property (forced && upper_rom_role_in
      |=> upper_select_out == rom_chip_select_out)
      else $error("upper select differs from ROM select");
   upper_dram_a: assert property (forced && !upper_rom_role_in
      |=> upper_select_out == dram_row_strobe_out)
      else $error("upper select differs from row strobe");
   width_pin_a: assert property (##1 width_oe_n_out == 1'h0
      && width_level_out != $past(bus_width_select_in))
      else $error("width pin level wrong");
   switch_strobe_a: assert property (cause_ff == pin_state_pkg::CAUSE_SWITCH
      |=> dram_row_strobe_out.level == 2'h0 && dram_row_strobe_out.oe_n == 2'h0)
      else $error("strobe not low after switch reset");
   deadman_strobe_a: assert property (!rtc_active_ff && !sw_pressed_ff && watchdog_timeout_in
      |=> ##1 dram_row_strobe_out.level == 2'h3)
      else $error("strobe not high after watchdog reset");
   hold_clock_a: assert property (holding && !hold_from_suspend_ff
      |=> external_bus_clock_out == $past(external_bus_clock_live_in))
      else $error("bus clock stopped in hold");
   serial_role_a: assert property (running && full_speed && !bus_hold_grant_in
      |=> serial_level_out == $past(serial_mux) && serial_oe_n_out == '0)
      else $error("serial pin role wrong");
   hold_normal_a: assert property (holding
      |=> serial_level_out == $past(serial_mux))
      else $error("serial pin forced in hold");

   switch_reset_c: cover property (cause_ff == pin_state_pkg::CAUSE_SWITCH);
   deadman_reset_c: cover property (cause_ff == pin_state_pkg::CAUSE_DEADMAN);
   hold_suspend_c: cover property (holding && hold_from_suspend_ff);
   upper_rom_c: cover property (forced && upper_rom_role_in);

endmodule : pin_state_mode_control

// [bench/ext_memory_model.sv]
`timescale 1ns/1ps
// Far-side memory: reports self refresh and counts bus clock rising edges
module ext_memory_model (
   // Pins from the device
   input wire pin_state_pkg::pin_pair_type dram_row_strobe_in,
   input wire logic external_bus_clock_in,
   // Bench control
   input wire logic count_clear_in,
   // Observations
   output logic self_refresh_out,
   output logic [7:0] clock_edges_out
);
   // ---------------------------------------------------------------
   // Self refresh needs both strobes driven low
   // ---------------------------------------------------------------
   assign self_refresh_out = (dram_row_strobe_in.level === 2'h0)
      && (dram_row_strobe_in.oe_n === 2'h0);

   // ---------------------------------------------------------------
   // Clock activity, frozen clock leaves the count at zero
   // ---------------------------------------------------------------
   always @(posedge external_bus_clock_in or posedge count_clear_in) begin
      if (count_clear_in) begin
         clock_edges_out <= 8'h00;
      end else begin
         clock_edges_out <= clock_edges_out + 8'h01;
      end
   end
endmodule : ext_memory_model

// [bench/tb_pin_state_mode_control.sv]
`timescale 1ns/1ps
module tb_pin_state_mode_control;
   logic mclk_in = 1'h0;
   logic rst_in = 1'h1;
   logic clk_rst = 1'h0, sw_n = 1'h1, wdog = 1'h0, run = 1'h0, hold = 1'h0;
   logic width_sel = 1'h0, rom_role = 1'h1, clk_live = 1'h0, clear = 1'h1;
   logic [2:0] role = 3'h0, ser_live = 3'h0, gpio_live = 3'h0;
   logic [1:0] rom_live = 2'h3, ras_live = 2'h3, up_live = 2'h3;
   pin_state_pkg::power_mode_type mode = pin_state_pkg::PM_FULL;
   pin_state_pkg::pin_pair_type rom_pins, ras_pins, up_pins;
   pin_state_pkg::reset_cause_type cause;
   logic bus_clk, width_lvl, width_oe_n, refresh;
   logic [2:0] ser_lvl, ser_oe_n;
   logic [7:0] edges;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #50 mclk_in = ~mclk_in;

   pin_state_mode_control #(.SERIAL_W(3)) u_dut (
      .mclk_in(mclk_in), .rst_in(rst_in),
      .clock_domain_reset_input_in(clk_rst), .reset_switch_input_n_in(sw_n),
      .watchdog_timeout_in(wdog), .run_start_in(run),
      .power_mode_in(mode), .bus_hold_grant_in(hold),
      .bus_width_select_in(width_sel), .upper_rom_role_in(rom_role),
      .serial_gpio_role_in(role),
      .rom_chip_select_n_live_in(rom_live), .dram_row_strobe_n_live_in(ras_live),
      .upper_select_n_live_in(up_live), .external_bus_clock_live_in(clk_live),
      .serial_live_in(ser_live), .gpio_live_in(gpio_live),
      .rom_chip_select_out(rom_pins), .dram_row_strobe_out(ras_pins),
      .upper_select_out(up_pins), .external_bus_clock_out(bus_clk),
      .width_level_out(width_lvl), .width_oe_n_out(width_oe_n),
      .serial_level_out(ser_lvl), .serial_oe_n_out(ser_oe_n),
      .reset_cause_out(cause));

   ext_memory_model u_mem (
      .dram_row_strobe_in(ras_pins), .external_bus_clock_in(bus_clk),
      .count_clear_in(clear), .self_refresh_out(refresh), .clock_edges_out(edges));

   // ---------------------------------------------------------------
   // Compare and housekeeping
   // ---------------------------------------------------------------
   task automatic compare_pair(input pin_state_pkg::pin_pair_type got,
                               input pin_state_pkg::pin_pair_type exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: pin pair %h, expected %h", $time, got, exp);
      end
   endtask : compare_pair

   task automatic compare_bits(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : compare_bits

   task automatic cycles_wait(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : cycles_wait

   task automatic test_done;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done

   // Hang guard, far above the roughly 135 cycles the run needs
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic rtc_after_reset;
      compare_bits({4'h0, cause}, {4'h0, pin_state_pkg::CAUSE_RTC});
      compare_pair(rom_pins, '{level: 2'h3, oe_n: 2'h3});
      compare_pair(up_pins, '{level: 2'h3, oe_n: 2'h3});
      compare_pair(ras_pins, '{level: 2'h3, oe_n: 2'h0});
      compare_bits({7'h00, bus_clk}, 8'h00);
   endtask : rtc_after_reset

   task automatic switch_reset;
      width_sel = 1'h1;
      sw_n = 1'h0;
      run = 1'h1;
      cycles_wait(8);
      sw_n = 1'h1;
      run = 1'h0;
      cycles_wait(8);
      compare_bits({4'h0, cause}, {4'h0, pin_state_pkg::CAUSE_SWITCH});
      compare_pair(ras_pins, '{level: 2'h0, oe_n: 2'h0});
      compare_bits({7'h00, refresh}, 8'h01);
      compare_pair(rom_pins, '{level: 2'h3, oe_n: 2'h0});
      compare_pair(up_pins, rom_pins);
      compare_bits({6'h00, width_lvl, width_oe_n}, 8'h00);
   endtask : switch_reset

   task automatic deadman_reset;
      width_sel = 1'h0;
      rom_role = 1'h0;
      wdog = 1'h1;
      cycles_wait(1);
      wdog = 1'h0;
      cycles_wait(4);
      compare_bits({4'h0, cause}, {4'h0, pin_state_pkg::CAUSE_DEADMAN});
      compare_pair(ras_pins, '{level: 2'h3, oe_n: 2'h0});
      compare_pair(up_pins, ras_pins);
      compare_bits({6'h00, width_lvl, width_oe_n}, 8'h02);
   endtask : deadman_reset

   task automatic running_roles;
      rom_live = 2'h1;
      ras_live = 2'h2;
      up_live = 2'h1;
      ser_live = 3'h5;
      gpio_live = 3'h2;
      role = 3'h6;
      run = 1'h1;
      cycles_wait(1);
      run = 1'h0;
      cycles_wait(4);
      compare_pair(rom_pins, '{level: 2'h1, oe_n: 2'h0});
      compare_pair(ras_pins, '{level: 2'h2, oe_n: 2'h0});
      compare_pair(up_pins, '{level: 2'h1, oe_n: 2'h0});
      compare_bits({2'h0, ser_lvl, ser_oe_n}, {2'h0, 3'h3, 3'h0});
      role = 3'h1;
      cycles_wait(3);
      compare_bits({2'h0, ser_lvl, ser_oe_n}, {2'h0, 3'h4, 3'h0});
   endtask : running_roles

   task automatic suspend_hold;
      clk_live = 1'h1;
      cycles_wait(3);
      mode = pin_state_pkg::PM_SUSPEND;
      clk_live = 1'h0;
      ser_live = 3'h0;
      gpio_live = 3'h5;
      cycles_wait(3);
      compare_bits({4'h0, bus_clk, ser_lvl}, {4'h0, 1'h1, 3'h4});
      compare_pair(ras_pins, '{level: 2'h0, oe_n: 2'h0});
      hold = 1'h1;
      clear = 1'h0;
      repeat (10) begin
         clk_live = ~clk_live;
         cycles_wait(2);
      end
      compare_bits(edges, 8'h00);
      compare_bits({7'h00, bus_clk}, 8'h01);
   endtask : suspend_hold

   task automatic full_hold;
      hold = 1'h0;
      mode = pin_state_pkg::PM_FULL;
      clk_live = 1'h0;
      cycles_wait(3);
      hold = 1'h1;
      clear = 1'h1;
      cycles_wait(3);
      clear = 1'h0;
      repeat (10) begin
         clk_live = ~clk_live;
         cycles_wait(2);
      end
      compare_bits(edges, 8'h05);
      compare_pair(rom_pins, '{level: 2'h3, oe_n: 2'h0});
      compare_bits({6'h00, ras_pins.oe_n}, 8'h03);
   endtask : full_hold

   task automatic hibernate_standby;
      hold = 1'h0;
      mode = pin_state_pkg::PM_HIBERNATE;
      cycles_wait(3);
      compare_pair(rom_pins, '{level: 2'h3, oe_n: 2'h3});
      compare_pair(ras_pins, '{level: 2'h0, oe_n: 2'h0});
      compare_pair(up_pins, ras_pins);
      compare_bits({1'h0, bus_clk, ser_lvl, ser_oe_n}, {1'h0, 1'h0, 3'h7, 3'h0});
      mode = pin_state_pkg::PM_STANDBY;
      cycles_wait(3);
      hold = 1'h1;
      clear = 1'h1;
      cycles_wait(2);
      clear = 1'h0;
      repeat (6) begin
         clk_live = ~clk_live;
         cycles_wait(2);
      end
      compare_bits(edges, 8'h03);
   endtask : hibernate_standby

   task automatic rtc_pin_reset;
      hold = 1'h0;
      clk_rst = 1'h1;
      run = 1'h1;
      cycles_wait(6);
      clk_rst = 1'h0;
      run = 1'h0;
      cycles_wait(6);
      compare_bits({4'h0, cause}, {4'h0, pin_state_pkg::CAUSE_RTC});
      compare_pair(ras_pins, '{level: 2'h3, oe_n: 2'h0});
      compare_pair(up_pins, ras_pins);
      compare_bits({2'h0, ser_lvl, ser_oe_n}, {2'h0, 3'h7, 3'h7});
   endtask : rtc_pin_reset

   initial begin
      cycles_wait(20);
      rst_in = 1'h0;
      cycles_wait(2);
      rtc_after_reset();
      switch_reset();
      deadman_reset();
      running_roles();
      suspend_hold();
      full_hold();
      hibernate_standby();
      rtc_pin_reset();
      test_done();
   end
endmodule : tb_pin_state_mode_control
